/* File: src/tbc_defs.svh */
`ifndef TBC_DEFS_SVH
`define TBC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------------
`define TBC_ADDR_THR_WIPER 4'h0
`define TBC_ADDR_THR_SCALED 4'h1
`define TBC_ADDR_THR_MAPPED 4'h2
`define TBC_ADDR_THR_FINAL 4'h3
`define TBC_ADDR_THR_OVERRIDE 4'h4
`define TBC_ADDR_THR_GAIN 4'h5
`define TBC_ADDR_THR_BIAS 4'h6
`define TBC_ADDR_BRK_WIPER 4'h7
`define TBC_ADDR_BRK_SCALED 4'h8
`define TBC_ADDR_BRK_MAPPED 4'h9
`define TBC_ADDR_BRK_OVERRIDE 4'ha
`define TBC_ADDR_BRK_FINAL 4'hb
`define TBC_ADDR_CONFIG 4'hc
`define TBC_ADDR_SETUP 4'hd

// ----------------------------------------------------------------------------
// Config and setup register fields
// ----------------------------------------------------------------------------
`define TBC_CFG_THR_TYPE_LSB 0
`define TBC_CFG_BRK_TYPE_LSB 4
`define TBC_CFG_PUMP_BIT 8
`define TBC_CFG_PEDAL_BIT 9
`define TBC_SETUP_THR_BIT 0
`define TBC_SETUP_BRK_BIT 1

// ----------------------------------------------------------------------------
// Reset values and fixed figures
// ----------------------------------------------------------------------------
`define TBC_RST_GAIN 16'h0080
`define TBC_RST_BIAS 16'h0000
`define TBC_RST_OVERRIDE 16'h0000
`define TBC_RST_CONFIG 16'h0001
`define TBC_TYPE_PROGRAM 3'h5
`define TBC_STATE_RUN_A 4'h5
`define TBC_STATE_RUN_B 4'ha
`define TBC_GAIN_SHIFT 7
`define TBC_POT_MAX 16'h7fff

`endif

/* File: src/tbc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module tbc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wrPtr_ff;
  logic [AW-1:0] rdPtr_ff;
  logic [AW:0] count_ff;
  logic doWr;
  logic doRd;

  assign inReady = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData = mem_ff[rdPtr_ff];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (doWr) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doWr) begin
        wrPtr_ff <= bump(wrPtr_ff);
      end
      if (doRd) begin
        rdPtr_ff <= bump(rdPtr_ff);
      end
      if (doWr && !doRd) begin
        count_ff <= count_ff + 1'b1;
      end else if (doRd && !doWr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/tbc_pkg.sv */
`default_nettype none
package tbc_pkg;

  typedef struct packed {
    logic [15:0] thrWiper;
    logic [15:0] brkWiper;
    logic [15:0] thrMapIn;
    logic [15:0] brkMapIn;
  } tbc_sample_s;

  typedef struct packed {
    logic signed [15:0] thrCmd;
    logic signed [15:0] brkCmd;
  } tbc_cmd_s;

  typedef enum logic [2:0] {
    TBC_IDLE = 3'b001,
    TBC_CALC = 3'b010,
    TBC_PUSH = 3'b100
  } tbc_state_e;

endpackage
`default_nettype wire

/* File: src/throttle_brake_command_chain.sv */
// How it works
// RULE_01 - Throttle type stage yields 16-bit raw command magnitude from wiper reading.
// RULE_02 - Mapped throttle of zero becomes +1 forward or -1 reverse.
// RULE_03 - Throttle type 5 selects the override register instead of mapped value.
// RULE_04 - Throttle times gain, divided by 128, plus bias gives mapped throttle.
// RULE_05 - Gain and bias are signed in multiply and add.
// RULE_06 - Software normally keeps gain at 128 for unity scaling.
// RULE_07 - Pump enable clamps mapped throttle to non-negative values.
// RULE_08 - Final throttle zero when interlock off, fault, or state not 5/10.
// RULE_09 - Brake type stage yields signed 16-bit value for brake mapping.
// RULE_10 - Brake type 5 selects the brake override register.
// RULE_11 - Brake value saturates to 0..32767, forming mapped brake.
// RULE_12 - Final brake zero while pedal enable is off.
// RULE_13 - Nonzero final brake forces delivered throttle to zero.
// RULE_14 - Type 5 scaled pot output stays zero until pot setup done.
// RULE_15 - Pot position 0..100 percent reads as 0..32767.
// RULE_16 - Both chains recompute per update strobe; results registered together.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defs.svh"
module throttle_brake_command_chain
  import tbc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic updateStrobe,
  output logic updateReady,
  input wire logic [15:0] thrWiperIn,
  input wire logic [15:0] brkWiperIn,
  input wire logic [15:0] thrCurveIn,
  input wire logic [15:0] brkCurveIn,
  input wire logic fwdSelect,
  input wire logic revSelect,
  input wire logic interlockOn,
  input wire logic faultZeroThrottle,
  input wire logic [3:0] mainState,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  output logic cmdValid,
  input wire logic cmdReady,
  output logic signed [15:0] thrCmdOut,
  output logic signed [15:0] brkCmdOut
);

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  logic [15:0] thrOverride_ff;
  logic [15:0] thrGain_ff;
  logic [15:0] thrBias_ff;
  logic [15:0] brkOverride_ff;
  logic [15:0] config_ff;
  logic thrSetup_ff;
  logic brkSetup_ff;
  logic [15:0] regRdData_ff;

  logic [2:0] thrType;
  logic [2:0] brkType;
  logic pumpOn;
  logic pedalOn;
  assign thrType = config_ff[`TBC_CFG_THR_TYPE_LSB +: 3];
  assign brkType = config_ff[`TBC_CFG_BRK_TYPE_LSB +: 3];
  assign pumpOn = config_ff[`TBC_CFG_PUMP_BIT];
  assign pedalOn = config_ff[`TBC_CFG_PEDAL_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thrOverride_ff <= `TBC_RST_OVERRIDE;
      thrGain_ff <= `TBC_RST_GAIN;
      thrBias_ff <= `TBC_RST_BIAS;
      brkOverride_ff <= `TBC_RST_OVERRIDE;
      config_ff <= `TBC_RST_CONFIG;
    end else if (regWrite) begin
      case (regAddr)
        `TBC_ADDR_THR_OVERRIDE: begin
          thrOverride_ff <= regWrData;
        end
        `TBC_ADDR_THR_GAIN: begin
          thrGain_ff <= regWrData;
        end
        `TBC_ADDR_THR_BIAS: begin
          thrBias_ff <= regWrData;
        end
        `TBC_ADDR_BRK_OVERRIDE: begin
          brkOverride_ff <= regWrData;
        end
        `TBC_ADDR_CONFIG: begin
          config_ff <= {6'h00, regWrData[9:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Pot setup is sticky; changing a type away from 5 drops it so a later return re-arms the clamp.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thrSetup_ff <= 1'b0;
      brkSetup_ff <= 1'b0;
    end else begin
      if (regWrite && regAddr == `TBC_ADDR_SETUP && regWrData[`TBC_SETUP_THR_BIT]) begin
        thrSetup_ff <= 1'b1;
      end else if (thrType != `TBC_TYPE_PROGRAM) begin
        thrSetup_ff <= 1'b0;
      end
      if (regWrite && regAddr == `TBC_ADDR_SETUP && regWrData[`TBC_SETUP_BRK_BIT]) begin
        brkSetup_ff <= 1'b1;
      end else if (brkType != `TBC_TYPE_PROGRAM) begin
        brkSetup_ff <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sample capture and sequencing
  // --------------------------------------------------------------------------
  tbc_state_e state_ff;
  tbc_sample_s sample_ff;
  tbc_cmd_s cmd;
  logic fifoInReady;

  assign updateReady = (state_ff == TBC_IDLE);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= TBC_IDLE;
    end else begin
      case (state_ff)
        TBC_IDLE: begin
          if (updateStrobe) begin
            state_ff <= TBC_CALC;
          end
        end
        TBC_CALC: begin
          state_ff <= TBC_PUSH;
        end
        TBC_PUSH: begin
          if (fifoInReady) begin
            state_ff <= TBC_IDLE;
          end
        end
        default: begin
          state_ff <= TBC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sample_ff <= '0;
    end else if (updateStrobe && state_ff == TBC_IDLE) begin
      sample_ff <= '{thrWiperIn, brkWiperIn, thrCurveIn, brkCurveIn}; // RULE_16
    end
  end

  // --------------------------------------------------------------------------
  // Arithmetic helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] potScale(input logic [15:0] raw);
    potScale = (raw > `TBC_POT_MAX) ? `TBC_POT_MAX : raw; // RULE_15
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) begin
      sat16 = 16'sh7fff;
    end else if (v < -34'sd32768) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Throttle chain
  // --------------------------------------------------------------------------
  logic [15:0] thrScaled;
  logic [15:0] thrRawMag;
  logic signed [15:0] thrNudged;
  logic signed [15:0] thrSelected;
  logic signed [31:0] thrProduct;
  logic signed [33:0] thrSum;
  logic signed [15:0] thrMapped;
  logic signed [15:0] thrLimited;
  logic runState;
  logic thrGate;

  assign thrScaled = (thrType == `TBC_TYPE_PROGRAM && !thrSetup_ff) ? 16'h0000 : potScale(sample_ff.thrWiper); // RULE_14
  // Magnitude only; direction comes from the mapping curve and select inputs.
  assign thrRawMag = potScale(sample_ff.thrWiper); // RULE_01

  always_comb begin
    thrNudged = $signed(sample_ff.thrMapIn);
    if (sample_ff.thrMapIn == 16'h0000) begin
      if (fwdSelect) begin
        thrNudged = 16'sd1; // RULE_02
      end else if (revSelect) begin
        thrNudged = -16'sd1; // RULE_02
      end
    end
  end

  assign thrSelected = (thrType == `TBC_TYPE_PROGRAM) ? $signed(thrOverride_ff) : thrNudged; // RULE_03
  assign thrProduct = thrSelected * $signed(thrGain_ff); // RULE_05
  // Arithmetic shift floors toward minus infinity; a gain of 128 is an exact identity.
  assign thrSum = 34'(thrProduct >>> `TBC_GAIN_SHIFT) + 34'($signed(thrBias_ff)); // RULE_04
  assign thrMapped = sat16(thrSum);
  assign thrLimited = (pumpOn && thrMapped < 16'sd0) ? 16'sd0 : thrMapped; // RULE_07
  assign runState = (mainState == `TBC_STATE_RUN_A) || (mainState == `TBC_STATE_RUN_B);
  assign thrGate = interlockOn && !faultZeroThrottle && runState;

  // --------------------------------------------------------------------------
  // Brake chain
  // --------------------------------------------------------------------------
  logic [15:0] brkScaled;
  logic signed [15:0] brkTyped;
  logic signed [15:0] brkSelected;
  logic signed [15:0] brkMapped;

  assign brkScaled = (brkType == `TBC_TYPE_PROGRAM && !brkSetup_ff) ? 16'h0000 : potScale(sample_ff.brkWiper); // RULE_14
  assign brkTyped = $signed(potScale(sample_ff.brkWiper)); // RULE_09
  assign brkSelected = (brkType == `TBC_TYPE_PROGRAM) ? $signed(brkOverride_ff) : $signed(sample_ff.brkMapIn); // RULE_10
  assign brkMapped = (brkSelected < 16'sd0) ? 16'sd0 : brkSelected; // RULE_11

  always_comb begin
    cmd.brkCmd = pedalOn ? brkMapped : 16'sd0; // RULE_12
    cmd.thrCmd = thrGate ? thrLimited : 16'sd0; // RULE_08
    if (cmd.brkCmd != 16'sd0) begin
      cmd.thrCmd = 16'sd0; // RULE_13
    end
  end

  // --------------------------------------------------------------------------
  // Observable results, latched once per update
  // --------------------------------------------------------------------------
  logic [15:0] thrWiperR_ff;
  logic [15:0] thrScaledR_ff;
  logic [15:0] thrMappedR_ff;
  logic [15:0] thrFinalR_ff;
  logic [15:0] brkWiperR_ff;
  logic [15:0] brkScaledR_ff;
  logic [15:0] brkMappedR_ff;
  logic [15:0] brkFinalR_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thrWiperR_ff <= '0;
      thrScaledR_ff <= '0;
      thrMappedR_ff <= '0;
      thrFinalR_ff <= '0;
      brkWiperR_ff <= '0;
      brkScaledR_ff <= '0;
      brkMappedR_ff <= '0;
      brkFinalR_ff <= '0;
    end else if (state_ff == TBC_CALC) begin
      thrWiperR_ff <= thrRawMag; // RULE_16
      thrScaledR_ff <= thrScaled;
      thrMappedR_ff <= thrMapped;
      thrFinalR_ff <= cmd.thrCmd;
      brkWiperR_ff <= brkTyped; // RULE_09
      brkScaledR_ff <= brkScaled;
      brkMappedR_ff <= brkMapped;
      brkFinalR_ff <= cmd.brkCmd;
    end
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData_ff <= '0;
    end else if (regRead) begin
      case (regAddr)
        `TBC_ADDR_THR_WIPER: regRdData_ff <= thrWiperR_ff;
        `TBC_ADDR_THR_SCALED: regRdData_ff <= thrScaledR_ff;
        `TBC_ADDR_THR_MAPPED: regRdData_ff <= thrMappedR_ff;
        `TBC_ADDR_THR_FINAL: regRdData_ff <= thrFinalR_ff;
        `TBC_ADDR_THR_OVERRIDE: regRdData_ff <= thrOverride_ff;
        `TBC_ADDR_THR_GAIN: regRdData_ff <= thrGain_ff;
        `TBC_ADDR_THR_BIAS: regRdData_ff <= thrBias_ff;
        `TBC_ADDR_BRK_WIPER: regRdData_ff <= brkWiperR_ff;
        `TBC_ADDR_BRK_SCALED: regRdData_ff <= brkScaledR_ff;
        `TBC_ADDR_BRK_MAPPED: regRdData_ff <= brkMappedR_ff;
        `TBC_ADDR_BRK_OVERRIDE: regRdData_ff <= brkOverride_ff;
        `TBC_ADDR_BRK_FINAL: regRdData_ff <= brkFinalR_ff;
        `TBC_ADDR_CONFIG: regRdData_ff <= config_ff;
        `TBC_ADDR_SETUP: regRdData_ff <= {14'h0000, brkSetup_ff, thrSetup_ff};
        default: regRdData_ff <= 16'h0000;
      endcase
    end else begin
      regRdData_ff <= 16'h0000;
    end
  end
  assign regRdData = regRdData_ff;

  // --------------------------------------------------------------------------
  // Command queue toward control mode processing
  // --------------------------------------------------------------------------
  // The queue stalls the sequencer, so a slow consumer holds off new updates.
  logic [31:0] fifoOut;
  tbc_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .inValid(state_ff == TBC_PUSH),
    .inReady(fifoInReady),
    .inData({thrFinalR_ff, brkFinalR_ff}),
    .outValid(cmdValid),
    .outReady(cmdReady),
    .outData(fifoOut)
  );
  assign thrCmdOut = $signed(fifoOut[31:16]);
  assign brkCmdOut = $signed(fifoOut[15:0]);

endmodule
`default_nettype wire

/* File: verification/tbc_chain_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module tbc_chain_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic updateStrobe,
  input wire logic updateReady,
  input wire logic [3:0] regAddr,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic signed [15:0] thrCmdOut,
  input wire logic signed [15:0] brkCmdOut
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_rd_quiet: assert property (!regRead |=> regRdData == 16'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_rd: assert property (regRead && regAddr >= 4'he |=> regRdData == 16'h0)
    else $error("unmapped read returned nonzero data");
  a_busy_after_take: assert property (updateStrobe && updateReady |=> !updateReady ##1 !updateReady)
    else $error("sequencer idle too soon after a taken update");
  a_push_lands: assert property (updateStrobe && updateReady && !cmdValid |-> ##3 cmdValid)
    else $error("update result did not reach the command output");
  a_head_stall: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(thrCmdOut) && $stable(brkCmdOut))
    else $error("command head changed while stalled");
  a_brake_wins: assert property (cmdValid && brkCmdOut != 16'sh0 |-> thrCmdOut == 16'sh0)
    else $error("throttle delivered beside a nonzero brake");
  a_brake_range: assert property (cmdValid |-> !brkCmdOut[15])
    else $error("negative brake command delivered");
  a_idle_return: assert property (updateStrobe && updateReady && !cmdValid |-> ##3 updateReady)
    else $error("sequencer not idle again after pushing into an empty queue");
endmodule
bind throttle_brake_command_chain tbc_chain_asserts tbc_chain_asserts_inst (
  .mclk(mclk),
  .rst_n(rst_n),
  .updateStrobe(updateStrobe),
  .updateReady(updateReady),
  .regAddr(regAddr),
  .regRead(regRead),
  .regRdData(regRdData),
  .cmdValid(cmdValid),
  .cmdReady(cmdReady),
  .thrCmdOut(thrCmdOut),
  .brkCmdOut(brkCmdOut)
);
`default_nettype wire

/* File: verification/tbc_cmd_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Control mode stage model: takes commands, may stall on request.
// ----------------------------------------------------------------------------
module tbc_cmd_sink (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic cmdValid,
  input wire logic signed [15:0] thrCmdOut,
  input wire logic signed [15:0] brkCmdOut,
  output logic cmdReady,
  output logic [15:0] popCount,
  output logic signed [15:0] lastThr,
  output logic signed [15:0] lastBrk
);
  // Ready is registered so it only ever moves just after a clock edge.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmdReady <= 1'b0;
      popCount <= 16'h0;
      lastThr <= 16'sh0;
      lastBrk <= 16'sh0;
    end else begin
      cmdReady <= !stall;
      if (cmdValid && cmdReady) begin
        popCount <= popCount + 16'h1;
        lastThr <= thrCmdOut;
        lastBrk <= brkCmdOut;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/throttle_brake_command_chain_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defs.svh"
module throttle_brake_command_chain_tb;
  import tbc_pkg::*;
  logic mclk, rst_n, updateStrobe, fwdSelect, revSelect, interlockOn, faultZeroThrottle, regWrite, regRead, stall;
  logic [15:0] thrWiperIn, brkWiperIn, thrCurveIn, brkCurveIn, regWrData, regRdData, popCount, p0, expThr;
  logic signed [15:0] thrCmdOut, brkCmdOut, lastThr, lastBrk;
  logic [3:0] mainState, regAddr;
  logic updateReady, cmdValid, cmdReady;
  int errCount = 0;
  int totalChecks = 0;

  throttle_brake_command_chain #(.FIFO_DEPTH(4)) throttle_brake_command_chain_inst (.mclk(mclk), .rst_n(rst_n),
    .updateStrobe(updateStrobe), .updateReady(updateReady), .thrWiperIn(thrWiperIn), .brkWiperIn(brkWiperIn),
    .thrCurveIn(thrCurveIn), .brkCurveIn(brkCurveIn), .fwdSelect(fwdSelect), .revSelect(revSelect),
    .interlockOn(interlockOn), .faultZeroThrottle(faultZeroThrottle), .mainState(mainState), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .thrCmdOut(thrCmdOut), .brkCmdOut(brkCmdOut));
  tbc_cmd_sink tbc_cmd_sink_inst (.mclk(mclk), .rst_n(rst_n), .stall(stall), .cmdValid(cmdValid),
    .thrCmdOut(thrCmdOut), .brkCmdOut(brkCmdOut), .cmdReady(cmdReady), .popCount(popCount),
    .lastThr(lastThr), .lastBrk(lastBrk));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------------
  // Bus cycles, updates and comparisons
  // ----------------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask

  task automatic upd(input logic [15:0] tc, input logic [15:0] bc);
    int n;
    n = 0;
    #1;
    while (updateReady !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 50) errCount++;
    @(posedge mclk);
    thrCurveIn <= tc;
    brkCurveIn <= bc;
    updateStrobe <= 1'b1;
    @(posedge mclk);
    updateStrobe <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  function automatic logic [15:0] thr_model(logic signed [15:0] c, logic signed [15:0] o, logic signed [15:0] g,
      logic signed [15:0] b, logic [2:0] t, logic f, logic r);
    logic signed [31:0] p;
    logic signed [15:0] s;
    s = (c != 16'sh0) ? c : (f ? 16'sh1 : (r ? -16'sh1 : 16'sh0));
    if (t == `TBC_TYPE_PROGRAM) s = o;
    p = s * g;
    p = (p >>> `TBC_GAIN_SHIFT) + b;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction

  task automatic thr_case(input logic [2:0] t, input logic pump, input logic f, input logic r,
      input logic [15:0] c, input logic [15:0] o, input logic [15:0] g, input logic [15:0] b);
    wr(`TBC_ADDR_CONFIG, {6'h0, 1'b0, pump, 1'b0, 3'h1, 1'b0, t});
    wr(`TBC_ADDR_THR_OVERRIDE, o);
    wr(`TBC_ADDR_THR_GAIN, g);
    wr(`TBC_ADDR_THR_BIAS, b);
    fwdSelect <= f;
    revSelect <= r;
    upd(c, 16'h0);
    expThr = thr_model(c, o, g, b, t, f, r);
    // The mapped value is observed ahead of the pump limiter, the final one after it.
    chk_reg(`TBC_ADDR_THR_MAPPED, expThr);
    chk_reg(`TBC_ADDR_THR_FINAL, (pump && expThr[15]) ? 16'h0 : expThr);
  endtask

  task automatic brk_case(input logic [2:0] t, input logic pedal, input logic [15:0] c, input logic [15:0] o,
      input logic [15:0] m);
    wr(`TBC_ADDR_CONFIG, {6'h0, pedal, 1'b0, 1'b0, t, 1'b0, 3'h1});
    wr(`TBC_ADDR_BRK_OVERRIDE, o);
    upd(16'd1000, c);
    chk_reg(`TBC_ADDR_BRK_MAPPED, m);
    chk_reg(`TBC_ADDR_BRK_FINAL, pedal ? m : 16'h0);
    chk(lastBrk, pedal ? m : 16'h0);
    chk(lastThr, (pedal && m != 16'h0) ? 16'h0 : 16'd1000);
  endtask

  initial begin
    #200000;
    errCount++;
    give_verdict();
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    {rst_n, updateStrobe, fwdSelect, revSelect, faultZeroThrottle, regWrite, regRead, stall} = 8'h0;
    {thrWiperIn, brkWiperIn, thrCurveIn, brkCurveIn, regWrData, regAddr} = 84'h0;
    interlockOn = 1'b1;
    mainState = `TBC_STATE_RUN_A;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    chk_reg(`TBC_ADDR_THR_GAIN, `TBC_RST_GAIN);
    chk_reg(`TBC_ADDR_THR_BIAS, `TBC_RST_BIAS);
    chk_reg(`TBC_ADDR_THR_OVERRIDE, `TBC_RST_OVERRIDE);
    chk_reg(`TBC_ADDR_CONFIG, `TBC_RST_CONFIG);
    wr(4'he, 16'hbeef);
    chk_reg(4'he, 16'h0);
    thr_case(3'h1, 1'b0, 1'b0, 1'b0, 16'd1000, 16'h0, 16'h0080, 16'h0);
    thr_case(3'h1, 1'b0, 1'b1, 1'b0, 16'h0, 16'h0, 16'h0080, 16'h0);
    thr_case(3'h1, 1'b0, 1'b0, 1'b1, 16'h0, 16'h0, 16'h0080, 16'h0);
    thr_case(3'h1, 1'b0, 1'b1, 1'b1, 16'h0, 16'h0, 16'h0080, 16'h0);
    thr_case(3'h1, 1'b0, 1'b0, 1'b0, 16'd300, 16'h0, 16'hffc0, 16'hfffb);
    thr_case(3'h1, 1'b1, 1'b0, 1'b0, 16'hfc18, 16'h0, 16'h0080, 16'h0);
    thr_case(3'h1, 1'b0, 1'b0, 1'b0, 16'hfc18, 16'h0, 16'h0080, 16'h0);
    thr_case(3'h5, 1'b0, 1'b0, 1'b0, 16'd777, 16'd1234, 16'h0080, 16'h0);
    thr_case(3'h2, 1'b0, 1'b0, 1'b0, 16'd777, 16'd1234, 16'h0080, 16'h0);
    thr_case(3'h1, 1'b0, 1'b0, 1'b0, 16'h7fff, 16'h0, 16'h0100, 16'h0);
    thr_case(3'h1, 1'b0, 1'b0, 1'b0, 16'd1000, 16'h0, 16'h0080, 16'h0);
    for (int s = 0; s < 16; s++) begin
      mainState <= s[3:0];
      upd(16'd1000, 16'h0);
      chk_reg(`TBC_ADDR_THR_FINAL, (s == 5 || s == 10) ? 16'd1000 : 16'h0);
    end
    mainState <= `TBC_STATE_RUN_B;
    interlockOn <= 1'b0;
    upd(16'd1000, 16'h0);
    chk_reg(`TBC_ADDR_THR_FINAL, 16'h0);
    interlockOn <= 1'b1;
    faultZeroThrottle <= 1'b1;
    upd(16'd1000, 16'h0);
    chk_reg(`TBC_ADDR_THR_FINAL, 16'h0);
    faultZeroThrottle <= 1'b0;
    wr(`TBC_ADDR_THR_MAPPED, 16'h5555);
    chk_reg(`TBC_ADDR_THR_MAPPED, 16'd1000);
    brk_case(3'h1, 1'b1, 16'd1234, 16'h0, 16'd1234);
    brk_case(3'h1, 1'b1, 16'hfffb, 16'h0, 16'h0);
    brk_case(3'h1, 1'b1, 16'h7fff, 16'h0, 16'h7fff);
    brk_case(3'h5, 1'b1, 16'd99, 16'd20000, 16'd20000);
    brk_case(3'h5, 1'b1, 16'd99, 16'hfffd, 16'h0);
    brk_case(3'h1, 1'b0, 16'd1234, 16'h0, 16'd1234);
    thrWiperIn <= 16'h9c40;
    brkWiperIn <= 16'h1234;
    wr(`TBC_ADDR_CONFIG, 16'h0055);
    upd(16'h0, 16'h0);
    chk_reg(`TBC_ADDR_THR_SCALED, 16'h0);
    chk_reg(`TBC_ADDR_BRK_SCALED, 16'h0);
    wr(`TBC_ADDR_SETUP, 16'h0003);
    upd(16'h0, 16'h0);
    chk_reg(`TBC_ADDR_THR_SCALED, `TBC_POT_MAX);
    chk_reg(`TBC_ADDR_BRK_SCALED, 16'h1234);
    chk_reg(`TBC_ADDR_THR_WIPER, `TBC_POT_MAX);
    chk_reg(`TBC_ADDR_BRK_WIPER, 16'h1234);
    // Stall the far side so the four-entry buffer fills and the fifth push must wait.
    stall <= 1'b1;
    repeat (3) @(posedge mclk);
    p0 = popCount;
    repeat (5) upd(16'd1000, 16'h0);
    chk({15'h0, updateReady}, 16'h0);
    chk({15'h0, cmdValid}, 16'h1);
    stall <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(popCount - p0, 16'd5);
    chk({15'h0, cmdValid}, 16'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
